/* hdl/pin_sync.sv */
// multi-flop synchroniser for an input pin
`timescale 1ns/1ns
`include "timer_defs.svh"
module pin_sync #(
    parameter int STAGES = `TM_SYNC_STAGES
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic pin,
    output logic level
);
    import timer_pkg::*;

    logic [STAGES-1:0] stage;
    logic [STAGES-1:0] next_stage;

    initial begin
        if (STAGES < 2) begin
            $error("pin_sync needs at least two stages");
        end
    end

    // only the next stage ever looks at an inner stage output; the last drives level
    genvar gi;
    generate
        for (gi = 0; gi < STAGES; gi = gi + 1) begin : g_stage
            if (gi == 0) begin : g_first
                always_comb begin
                    next_stage[gi] = pin;
                end
            end else begin : g_rest
                always_comb begin
                    next_stage[gi] = stage[gi-1];
                end
            end
        end
    endgenerate

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            stage <= '0;
        end else if (clk_en) begin
            stage <= next_stage;
        end
    end

    assign level = stage[STAGES-1];
endmodule

/* hdl/timer16.sv */
// sixteen-bit timer counter with prescaler and buffered wide access
//
// How it works
// - prescaler divides count clock by 1/2/4/8
// - hidden prescaler cleared by plain byte writes
// - no-sync mode skips the phase alignment stage
// - async external mode counts during sleep, wakes
// - mode switch may drop or add one count
// - byte reads are clean snapshots; plain-mode pairs can tear
// - wide access makes sixteen bits move together
// - wide mode high byte goes to buffer
// - wide low read captures high into buffer
// - wide high read returns captured buffer
// - wide low write loads high from buffer
// - wide high write leaves prescaler alone
// - external-source counting needs the pin seen low while running first
`timescale 1ns/1ns
`include "timer_defs.svh"
module timer16 #(
    parameter int CNT_W = `TM_CNT_W
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire timer_pkg::timer_control_reg_s ctrl,
    input wire timer_pkg::reg_access_s acc,
    input wire logic int_tick,
    input wire logic ext_clk_in,
    input wire logic sleep,
    input wire logic ovf_clear,
    output logic [`TM_BYTE_W-1:0] rdata,
    output logic [`TM_CNT_W-1:0] count_value,
    output logic ovf_flag,
    output logic wake
);
    import timer_pkg::*;

    initial begin
        if (CNT_W != 2 * `TM_BYTE_W) begin
            $error("timer16 serves only a two-byte count");
        end
    end

    function automatic logic [`TM_PRE_W-1:0] pre_mask(
        input logic [`TM_SEL_W-1:0] sel
    );
        case (sel)
            `TM_SEL_DIV1: pre_mask = `TM_MASK_DIV1;
            `TM_SEL_DIV2: pre_mask = `TM_MASK_DIV2;
            `TM_SEL_DIV4: pre_mask = `TM_MASK_DIV4;
            default: pre_mask = `TM_MASK_DIV8;
        endcase
    endfunction

    logic ext_s;
    logic ext_d;
    logic ext_prev;
    logic next_ext_d;
    logic next_ext_prev;
    logic pin_lvl;
    logic rise;
    logic run;
    logic src_ev;
    logic hit;
    logic inc;
    edge_arm_e arm;
    edge_arm_e next_arm;
    logic [`TM_PRE_W-1:0] pre;
    logic [`TM_PRE_W-1:0] next_pre;
    logic [`TM_CNT_W-1:0] count;
    logic [`TM_CNT_W-1:0] next_count;
    logic [`TM_BYTE_W-1:0] hbuf;
    logic [`TM_BYTE_W-1:0] next_hbuf;
    logic [`TM_BYTE_W-1:0] next_rdata;
    logic next_ovf;
    logic wr_lo;
    logic wr_hi;
    logic rd_lo;
    logic rd_hi;
    logic cnt_wr;
    logic pre_clr;

    pin_sync #(
        .STAGES(`TM_SYNC_STAGES)
    ) u_ext_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .pin(ext_clk_in),
        .level(ext_s)
    );

    assign wr_lo = acc.wr && !acc.sel_high;
    assign wr_hi = acc.wr && acc.sel_high;
    assign rd_lo = acc.rd && !acc.sel_high;
    assign rd_hi = acc.rd && acc.sel_high;

    // the extra stage stands in for phase alignment; bypassing it on a
    // mode change can shift the edge by one sample
    assign pin_lvl = ctrl.no_sync ? ext_s : ext_d;
    assign rise = pin_lvl && !ext_prev;
    // sleep stops the internal clocks, only the async external path runs
    assign run = ctrl.timer_on &&
                 (!sleep || (ctrl.ext_source && ctrl.no_sync));
    assign src_ev = run && (ctrl.ext_source ?
                            (rise && arm == armed) : int_tick);
    assign hit = (pre == pre_mask(ctrl.prescale_select));
    assign inc = src_ev && hit;
    // a high-byte write in wide mode only fills the buffer
    assign cnt_wr = wr_lo || (wr_hi && !ctrl.wide_access_enable);
    assign pre_clr = cnt_wr;

    always_comb begin
        next_ext_d = ext_s;
        next_ext_prev = pin_lvl;
        next_arm = arm;
        if (!ctrl.timer_on || !ctrl.ext_source) begin
            next_arm = wait_fall;
        end else begin
            case (arm)
                wait_fall: begin
                    if (!pin_lvl) begin
                        next_arm = armed;
                    end
                end
                armed: next_arm = armed;
                default: next_arm = wait_fall;
            endcase
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ext_d <= 1'b0;
            ext_prev <= 1'b0;
            arm <= wait_fall;
        end else if (clk_en) begin
            ext_d <= next_ext_d;
            ext_prev <= next_ext_prev;
            arm <= next_arm;
        end
    end

    always_comb begin
        next_pre = pre;
        next_count = count;
        next_hbuf = hbuf;
        next_rdata = rdata;
        next_ovf = ovf_flag;
        if (pre_clr) begin
            next_pre = `TM_PRE_RST;
        end else if (src_ev) begin
            next_pre = hit ? `TM_PRE_RST : pre + `TM_PRE_ONE;
        end
        if (inc) begin
            next_count = count + `TM_CNT_W'(1);
        end
        // writes beat a same-cycle increment in the bytes they load; see the software ordering
        if (wr_lo) begin
            if (ctrl.wide_access_enable) begin
                next_count = {hbuf, acc.wdata};
            end else begin
                next_count[`TM_LO_MSB:0] = acc.wdata;
            end
        end
        if (wr_hi) begin
            if (ctrl.wide_access_enable) begin
                next_hbuf = acc.wdata;
            end else begin
                next_count[`TM_HI_MSB:`TM_HI_LSB] = acc.wdata;
            end
        end
        // one clock domain, so each byte read is a clean snapshot
        if (rd_lo) begin
            next_rdata = count[`TM_LO_MSB:0];
            if (ctrl.wide_access_enable && !wr_hi) begin
                next_hbuf = count[`TM_HI_MSB:`TM_HI_LSB];
            end
        end else if (rd_hi) begin
            next_rdata = ctrl.wide_access_enable ? hbuf :
                         count[`TM_HI_MSB:`TM_HI_LSB];
        end
        if (ovf_clear) begin
            next_ovf = 1'b0;
        end
        if (inc && count == `TM_CNT_MAX && !cnt_wr) begin
            next_ovf = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pre <= `TM_PRE_RST;
            count <= `TM_CNT_RST;
            hbuf <= `TM_BYTE_RST;
            rdata <= `TM_BYTE_RST;
            ovf_flag <= 1'b0;
        end else if (clk_en) begin
            pre <= next_pre;
            count <= next_count;
            hbuf <= next_hbuf;
            rdata <= next_rdata;
            ovf_flag <= next_ovf;
        end
    end

    assign count_value = count;
    assign wake = ovf_flag && sleep;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    a_pre_clear_low: assert property (
        clk_en && wr_lo |=> pre == `TM_PRE_RST)
        else $error("prescaler not cleared by low write");
    a_hi_wr_keep: assert property (
        clk_en && wr_hi && ctrl.wide_access_enable && !src_ev
        |=> pre == $past(pre) && hbuf == $past(acc.wdata))
        else $error("wide high write touched prescaler");
    a_hi_no_live: assert property (
        clk_en && wr_hi && ctrl.wide_access_enable && !inc && !wr_lo
        |=> count == $past(count))
        else $error("wide high write reached live count");
    a_low_rd_cap: assert property (
        clk_en && rd_lo && !acc.wr && ctrl.wide_access_enable
        |=> hbuf == $past(count[`TM_HI_MSB:`TM_HI_LSB]) &&
            rdata == $past(count[`TM_LO_MSB:0]))
        else $error("low read did not capture high byte");
    a_hi_rd_buf: assert property (
        clk_en && rd_hi && ctrl.wide_access_enable |=> rdata == $past(hbuf))
        else $error("high read not from buffer");
    a_low_wr_pair: assert property (
        clk_en && wr_lo && ctrl.wide_access_enable
        |=> count == {$past(hbuf), $past(acc.wdata)})
        else $error("low write did not load sixteen bits");
    a_off_hold: assert property (
        clk_en && !ctrl.timer_on && !acc.wr
        |=> count == $past(count) && pre == $past(pre))
        else $error("count moved while timer off");
    a_sleep_stop: assert property (
        sleep && !(ctrl.ext_source && ctrl.no_sync) |-> !src_ev)
        else $error("synchronous count ran in sleep");
    a_first_fall: assert property (
        ctrl.ext_source && arm == wait_fall |-> !src_ev)
        else $error("counted before first falling edge");
    // a finished prescale period must restart the divider and step once
    a_pre_period: assert property (
        clk_en && inc && !cnt_wr
        |=> pre == `TM_PRE_RST && count == $past(count) + `TM_CNT_W'(1))
        else $error("increment did not restart prescaler");
    a_ovf_set: assert property (
        clk_en && inc && count == `TM_CNT_MAX && !cnt_wr
        |=> ovf_flag && count == `TM_CNT_RST)
        else $error("wrap did not set overflow");

    c_wrap: cover property (clk_en && inc && count == `TM_CNT_MAX);
    c_wide_read: cover property (rd_lo && ctrl.wide_access_enable
                                 ##[1:20] rd_hi);
    c_sleep_count: cover property (sleep && src_ev);
    c_div8_inc: cover property (inc && ctrl.prescale_select == `TM_SEL_DIV8);
endmodule

/* pkg/timer_defs.svh */
// constants for the sixteen-bit timer counter
`ifndef TIMER_DEFS_SVH
`define TIMER_DEFS_SVH
`define TM_BYTE_W 8
`define TM_CNT_W 16
`define TM_PRE_W 3
`define TM_SEL_W 2
`define TM_CNT_MAX 16'hffff
`define TM_CNT_RST 16'h0000
`define TM_BYTE_RST 8'h00
`define TM_PRE_RST 3'h0
`define TM_PRE_ONE 3'h1
`define TM_MASK_DIV1 3'h0
`define TM_MASK_DIV2 3'h1
`define TM_MASK_DIV4 3'h3
`define TM_MASK_DIV8 3'h7
`define TM_SEL_DIV1 2'h0
`define TM_SEL_DIV2 2'h1
`define TM_SEL_DIV4 2'h2
`define TM_SEL_DIV8 2'h3
`define TM_LO_MSB 7
`define TM_HI_LSB 8
`define TM_HI_MSB 15
`define TM_SYNC_STAGES 2
`endif

/* pkg/timer_pkg.sv */
// types shared by the timer counter and its users
package timer_pkg;
`include "timer_defs.svh"

    typedef struct packed {
        logic timer_on;
        logic ext_source;
        logic no_sync;
        logic wide_access_enable;
        logic [`TM_SEL_W-1:0] prescale_select;
    } timer_control_reg_s;

    typedef struct packed {
        logic rd;
        logic wr;
        logic sel_high;
        logic [`TM_BYTE_W-1:0] wdata;
    } reg_access_s;

    typedef enum logic {
        wait_fall,
        armed
    } edge_arm_e;
endpackage

/* sim/ext_clk_src.sv */
// slow asynchronous count-pin source for the timer bench
`timescale 1ns/1ns
module ext_clk_src #(
    parameter int HALF_NS = 130
) (
    input wire logic go,
    input wire logic idle_high,
    input wire logic [7:0] n_edges,
    output logic ext_clk_in
);
    // pin parks at its idle level between bursts, it never runs free
    initial begin
        ext_clk_in = 1'b0;
        forever begin
            @(posedge go or idle_high);
            ext_clk_in = idle_high;
            if (go) begin
                // parked high means each pulse falls first
                repeat (n_edges) begin
                    #(HALF_NS) ext_clk_in = ~idle_high;
                    #(HALF_NS) ext_clk_in = idle_high;
                end
            end
        end
    end
endmodule

/* sim/timer16_tb_top.sv */
// self-checking bench for the sixteen-bit timer counter
`timescale 1ns/1ns
module timer16_tb_top;
    import timer_pkg::*;
    logic clk;
    logic sys_rst = 1'b1;
    timer_control_reg_s ctrl = '0;
    reg_access_s acc = '0;
    logic int_tick = 1'b0;
    logic sleep = 1'b0;
    logic ovf_clear = 1'b0;
    logic go = 1'b0;
    logic idle_high = 1'b0;
    logic [7:0] n_edges = 8'h00;
    logic ext_clk_in;
    logic [7:0] rdata;
    logic ovf_flag;
    logic wake;
    logic clk_en = 1'b1;
    logic [15:0] count_value;
    logic rd_pend = 1'b0;
    logic [7:0] exp_q[$];
    logic [15:0] v;
    integer seed = 32'h954e;
    int fail_count = 0;
    int n_compared = 0;
    int cyc = 0;

    timer16 dut (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en),
        .ctrl(ctrl), .acc(acc), .int_tick(int_tick),
        .ext_clk_in(ext_clk_in), .sleep(sleep), .ovf_clear(ovf_clear),
        .rdata(rdata), .count_value(count_value),
        .ovf_flag(ovf_flag), .wake(wake));
    ext_clk_src src (.go(go), .idle_high(idle_high), .n_edges(n_edges),
        .ext_clk_in(ext_clk_in));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict;
        $display("compared %0d mismatched %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // one access per call; a gap cycle keeps strobes from merging
    task automatic op(input logic r, input logic w, input logic h,
                      input logic [7:0] d);
        @(negedge clk);
        acc = '{r, w, h, d};
        @(negedge clk);
        acc = '0;
    endtask

    task automatic rd(input logic h, input logic [7:0] e);
        exp_q.push_back(e);
        op(1'b1, 1'b0, h, 8'h00);
    endtask

    task automatic wr16(input logic [15:0] x);
        op(1'b0, 1'b1, 1'b1, x[15:8]);
        op(1'b0, 1'b1, 1'b0, x[7:0]);
    endtask

    task automatic tick_once;
        @(negedge clk);
        int_tick = 1'b1;
        @(negedge clk);
        int_tick = 1'b0;
    endtask

    // count is only written while stopped, so no write contention
    task automatic run(input int n);
        int gap;
        ctrl.timer_on = 1'b1;
        repeat (n) begin
            tick_once();
            gap = $random(seed) & 3;
            repeat (gap) @(negedge clk);
        end
        ctrl.timer_on = 1'b0;
    endtask

    task automatic pulses(input logic [7:0] n);
        n_edges = n;
        go = 1'b1;
        @(negedge clk);
        go = 1'b0;
        repeat (n * 8 + 10) @(negedge clk);
    endtask

    always @(posedge clk) rd_pend <= acc.rd;

    always @(negedge clk) begin
        if (rd_pend) begin
            check({8'h00, rdata}, {8'h00, exp_q.pop_front()});
        end
    end

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            give_verdict();
        end
    end

    initial begin
        repeat (10) @(negedge clk);
        sys_rst = 1'b0;
        rd(1'b0, 8'h00);
        rd(1'b1, 8'h00);
        $display("reset test done");
        for (int s = 0; s < 4; s++) begin
            ctrl.prescale_select = s[1:0];
            wr16(16'h0000);
            run((4 << s) - 1);
            tick_once();
            rd(1'b0, 8'h03);
            op(1'b0, 1'b1, 1'b1, 8'h00);
            run(1);
            rd(1'b0, (s == 0) ? 8'h04 : 8'h03);
        end
        $display("prescale test done");
        ctrl.wide_access_enable = 1'b1;
        ctrl.prescale_select = 2'h1;
        wr16(16'h0000);
        run(1);
        op(1'b0, 1'b1, 1'b1, 8'h00);
        run(1);
        rd(1'b0, 8'h01);
        v = 16'($random(seed));
        wr16(v);
        check(count_value, v);
        rd(1'b0, v[7:0]);
        rd(1'b1, v[15:8]);
        op(1'b0, 1'b1, 1'b1, ~v[15:8]);
        rd(1'b0, v[7:0]);
        rd(1'b1, v[15:8]);
        ctrl.wide_access_enable = 1'b0;
        rd(1'b1, v[15:8]);
        $display("wide test done");
        // with the clock enable low no tick may reach the count
        clk_en = 1'b0;
        run(2);
        clk_en = 1'b1;
        check(count_value, v);
        ctrl.prescale_select = 2'h0;
        ctrl.ext_source = 1'b1;
        ctrl.no_sync = 1'b1;
        sleep = 1'b1;
        wr16(16'h0000);
        ctrl.timer_on = 1'b1;
        pulses(8'd5);
        rd(1'b0, 8'h05);
        rd(1'b1, 8'h00);
        // enable lands in the very cycle the first synced rise shows up,
        // before any low was seen while running; timing assumes the
        // source's default half period and two sync stages
        ctrl.timer_on = 1'b0;
        wr16(16'h0000);
        n_edges = 8'd3;
        go = 1'b1;
        @(negedge clk);
        go = 1'b0;
        repeat (4) @(negedge clk);
        ctrl.timer_on = 1'b1;
        repeat (40) @(negedge clk);
        rd(1'b0, 8'h02);
        ctrl.timer_on = 1'b0;
        idle_high = 1'b1;
        wr16(16'h0000);
        ctrl.timer_on = 1'b1;
        pulses(8'd3);
        rd(1'b0, 8'h03);
        ctrl.no_sync = 1'b0;
        pulses(8'd2);
        rd(1'b0, 8'h03);
        ctrl.timer_on = 1'b0;
        wr16(16'hffff);
        ctrl.no_sync = 1'b1;
        ctrl.timer_on = 1'b1;
        pulses(8'd1);
        check(ovf_flag, 1'b1);
        check(wake, 1'b1);
        rd(1'b1, 8'h00);
        sleep = 1'b0;
        ovf_clear = 1'b1;
        @(negedge clk);
        ovf_clear = 1'b0;
        @(negedge clk);
        check(ovf_flag, 1'b0);
        check(wake, 1'b0);
        $display("external test done");
        repeat (2) @(negedge clk);
        give_verdict();
    end
endmodule
